//--- verilog/sp4_pkg.sv
// Constants and types for the four-mode serial port.
// Assumes a single core clock that also serves as the oscillator.
package sp4_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [2:0] ADDR_SERIAL_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_SERIAL_BUFFER = 3'h1;
	localparam logic [2:0] ADDR_POWER_CONTROL = 3'h2;
	localparam logic [2:0] ADDR_TIMER2_CONTROL = 3'h3;
	localparam logic [2:0] ADDR_TIMER1_RELOAD_HIGH = 3'h4;
	localparam logic [2:0] ADDR_TIMER2_RELOAD_HIGH = 3'h5;
	localparam logic [2:0] ADDR_TIMER2_RELOAD_LOW = 3'h6;
	localparam logic [2:0] ADDR_CLOCK_CONFIG = 3'h7;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_FILTER = 5;
	localparam int BIT_RX_ENABLE = 4;
	localparam int BIT_TX_NINTH = 3;
	localparam int BIT_RX_NINTH = 2;
	localparam int BIT_TX_DONE = 1;
	localparam int BIT_RX_DONE = 0;
	localparam int BIT_BAUD_DOUBLE = 7;
	localparam int BIT_RX_T2_SEL = 5;
	localparam int BIT_TX_T2_SEL = 4;
	localparam int BIT_SIX_CLOCK = 6;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ****************************************
	// Cycle counts
	// ****************************************
	localparam logic [3:0] SYNC_DIV_12T = 4'hc;
	localparam logic [3:0] SYNC_DIV_6T = 4'h6;
	localparam logic [3:0] T1_PRE_12T = 4'hc;
	localparam logic [3:0] T1_PRE_6T = 4'h6;
	localparam int OVERSAMPLE = 16;
	localparam int M2_DIV_12T = 64;
	localparam int M2_DIV_6T = 32;
	localparam logic [5:0] M2_TICK_12T = 6'(M2_DIV_12T / OVERSAMPLE);
	localparam logic [5:0] M2_TICK_6T = 6'(M2_DIV_6T / OVERSAMPLE);
	localparam logic [3:0] SUB_MID = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [3:0] SUB_LAST = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] LAST_BIT_M1 = 4'(10 - 1);
	localparam logic [3:0] LAST_BIT_M23 = 4'(11 - 1);
	localparam logic [3:0] DECIDE_BIT = 4'h9;
	localparam logic [3:0] M0_LAST_BIT = 4'(8 - 1);

	// ****************************************
	// Modes and states
	// ****************************************
	typedef enum logic [1:0] {SP4_M_SYNC, SP4_M_UART8, SP4_M_UART9_OSC, SP4_M_UART9_TMR} sp4_mode_t;
	typedef enum logic {SP4_TX_IDLE, SP4_TX_RUN} sp4_tx_st_t;
	typedef enum logic {SP4_RX_IDLE, SP4_RX_RUN} sp4_rx_st_t;
	typedef enum logic [1:0] {SP4_S0_IDLE, SP4_S0_TX, SP4_S0_RX} sp4_s0_st_t;

endpackage : sp4_pkg

//--- verilog/sp4_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ns
module sp4_sync (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Level
	input wire logic d,
	output logic q
);

	typedef struct packed {
		logic ff1;
		logic ff2;
	} sp4_sync_t;

	sp4_sync_t r;
	sp4_sync_t s;

	always_comb begin
		s.ff1 = d;
		s.ff2 = r.ff1;
	end

	// Idle-high line, so reset to high
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			r <= '1;
		end else begin
			r <= s;
		end
	end

	assign q = r.ff2;

endmodule : sp4_sync

//--- verilog/sp4_baud.sv
// Timer 1 and Timer 2 overflow sources, giving 16x bit-rate ticks.
// Assumes reload values come from the register file on the same clock.
`timescale 1ns/1ns
module sp4_baud import sp4_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Configuration
	input wire logic six_clock_mode_bit,
	input wire logic baud_double_bit,
	input wire logic [7:0] timer1_reload_high,
	input wire logic [7:0] timer2_reload_high,
	input wire logic [7:0] timer2_reload_low,
	// Ticks
	output logic t1_tick16,
	output logic t2_tick16
);

	typedef struct packed {
		logic [3:0] pre;
		logic [7:0] t1;
		logic t1_half;
		logic t2_pre;
		logic [15:0] t2;
		logic t1_tick;
		logic t2_tick;
	} sp4_baud_t;

	sp4_baud_t r;
	sp4_baud_t s;
	logic [3:0] pre_lim;

	always_comb begin
		s = r;
		s.t1_tick = 1'b0;
		s.t2_tick = 1'b0;
		// Faster prescale in 6-clock mode doubles Timer 1; Timer 2 skips its divide-by-2 instead
		pre_lim = (six_clock_mode_bit ? T1_PRE_6T : T1_PRE_12T) - 4'h1;
		s.pre = (r.pre == pre_lim) ? 4'h0 : r.pre + 4'h1;
		if (r.pre == pre_lim) begin
			// 8-bit auto-reload; halving skipped when doubled
			if (r.t1 == 8'hff) begin
				s.t1 = timer1_reload_high;
				s.t1_half = ~r.t1_half;
				s.t1_tick = baud_double_bit | r.t1_half;
			end else begin
				s.t1 = r.t1 + 8'h01;
			end
		end
		s.t2_pre = ~r.t2_pre;
		if (six_clock_mode_bit || r.t2_pre) begin
			// 16-bit reload from high and low bytes
			if (r.t2 == 16'hffff) begin
				s.t2 = {timer2_reload_high, timer2_reload_low};
				s.t2_tick = 1'b1;
			end else begin
				s.t2 = r.t2 + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= s;
		end
	end

	assign t1_tick16 = r.t1_tick;
	assign t2_tick16 = r.t2_tick;

endmodule : sp4_baud

//--- verilog/sp4_serial_port.sv
// Four-mode serial port with its register file.
// Assumes core_clk is the oscillator and pins are asynchronous.
// Function
// - Sync mode: data pin bidirectional, clock out, LSB first
// - Sync mode: buffer write sends 8 bits, sets done
// - Sync mode: receive while enabled and flag clear
// - Sync mode: bit rate equals shift clock
// - Mode 1 frame: start, 8 data, stop
// - Mode 1 baud from Timer 1 or 2, per direction
// - Double bit doubles Timer 1 baud
// - Mode 1 send; done flag at stop bit
// - Receive starts on falling edge, then rearms
// - Mode 1 accept rule at mid stop
// - Modes 2/3 frame: start, 8 data, ninth, stop
// - Mode 2 baud is oscillator over 64 or 32; here 32 or 16 in six-clock mode
// - Modes 2/3 send with ninth bit, then done
// - Modes 2/3 receive starts on falling edge
// - Modes 2/3 accept rule at mid ninth
// - Mode 3 is mode 2 with timer baud
// - Timer 1 baud formula, auto-reload
// - Timer 2 baud formula, 16-bit reload
// - Timer 2 interrupt suppressed as baud source
// - Six-clock mode doubles timer-derived baud
// - Buffer write and read are separate registers
// - Shift clock is oscillator over 12 or 6
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module sp4_serial_port import sp4_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Serial pins
	input wire logic data_pin_in,
	output logic data_pin_out,
	output logic data_pin_oe,
	output logic txd_pin_out,
	// Timer 2 interrupt gate
	output logic timer2_irq_suppress
);

	typedef struct packed {
		sp4_mode_t mode;
		logic filt;
		logic ren;
		logic tx9;
		logic rx9;
		logic txdone;
		logic rxdone;
		logic dbl;
		logic rx_t2;
		logic tx_t2;
		logic six;
		logic [7:0] th1;
		logic [7:0] rc2h;
		logic [7:0] rc2l;
		logic [7:0] rxbuf;
		logic [7:0] rdata;
		logic [5:0] m2cnt;
		logic m2tick;
		sp4_tx_st_t tx_st;
		logic [10:0] tx_sh;
		logic [3:0] tx_sub;
		logic [3:0] tx_bit;
		sp4_rx_st_t rx_st;
		logic [7:0] rx_sh;
		logic [3:0] rx_sub;
		logic [3:0] rx_bit;
		logic rx_prev;
		sp4_s0_st_t m0_st;
		logic [7:0] m0_sh;
		logic [3:0] m0_ph;
		logic [3:0] m0_bit;
		logic txd;
		logic dout;
		logic doe;
		logic supp;
	} sp4_state_t;

	sp4_state_t r;
	sp4_state_t s;
	logic rxd_s;
	logic t1_tick;
	logic t2_tick;
	logic tx_set;
	logic rx_set;
	logic serial_buffer_wr;
	logic tx_tick;
	logic rx_tick;
	logic [5:0] m2_lim;
	logic [3:0] m0_per;
	logic [3:0] tx_last;

	// Mode 2 uses the oscillator tick, modes 1 and 3 a timer
	function automatic logic pick_tick(sp4_mode_t m, logic t2_sel, logic t1, logic t2, logic osc);
		if (m == SP4_M_UART9_OSC) begin
			return osc;
		end
		return t2_sel ? t2 : t1;
	endfunction : pick_tick

	// ****************************************
	// Pin synchroniser and timers
	// ****************************************
	sp4_sync u_rxd_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.d(data_pin_in),
		.q(rxd_s)
	);

	sp4_baud u_baud (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.six_clock_mode_bit(r.six),
		.baud_double_bit(r.dbl),
		.timer1_reload_high(r.th1),
		.timer2_reload_high(r.rc2h),
		.timer2_reload_low(r.rc2l),
		.t1_tick16(t1_tick),
		.t2_tick16(t2_tick)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s = r;
		tx_set = 1'b0;
		rx_set = 1'b0;
		serial_buffer_wr = reg_wr && reg_addr == ADDR_SERIAL_BUFFER;
		m2_lim = (r.six ? M2_TICK_6T : M2_TICK_12T) >> r.dbl;
		s.m2tick = r.m2cnt >= m2_lim - 6'h01;
		s.m2cnt = s.m2tick ? 6'h00 : r.m2cnt + 6'h01;
		tx_tick = pick_tick(r.mode, r.tx_t2, t1_tick, t2_tick, r.m2tick);
		rx_tick = pick_tick(r.mode, r.rx_t2, t1_tick, t2_tick, r.m2tick);
		m0_per = r.six ? SYNC_DIV_6T : SYNC_DIV_12T;
		tx_last = (r.mode == SP4_M_UART8) ? LAST_BIT_M1 : LAST_BIT_M23;

		// Register writes; buffer writes go to the engines
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_SERIAL_CONTROL: begin
					s.mode = sp4_mode_t'(reg_wdata[BIT_MODE_HI:BIT_MODE_LO]);
					s.filt = reg_wdata[BIT_FILTER];
					s.ren = reg_wdata[BIT_RX_ENABLE];
					s.tx9 = reg_wdata[BIT_TX_NINTH];
					s.rx9 = reg_wdata[BIT_RX_NINTH];
					s.txdone = reg_wdata[BIT_TX_DONE];
					s.rxdone = reg_wdata[BIT_RX_DONE];
				end
				ADDR_POWER_CONTROL: s.dbl = reg_wdata[BIT_BAUD_DOUBLE];
				ADDR_TIMER2_CONTROL: begin
					s.rx_t2 = reg_wdata[BIT_RX_T2_SEL];
					s.tx_t2 = reg_wdata[BIT_TX_T2_SEL];
				end
				ADDR_TIMER1_RELOAD_HIGH: s.th1 = reg_wdata;
				ADDR_TIMER2_RELOAD_HIGH: s.rc2h = reg_wdata;
				ADDR_TIMER2_RELOAD_LOW: s.rc2l = reg_wdata;
				ADDR_CLOCK_CONFIG: s.six = reg_wdata[BIT_SIX_CLOCK];
				default: ;
			endcase
		end

		// Read data stands for one cycle only
		s.rdata = RESET_BYTE;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_SERIAL_CONTROL: begin
					s.rdata[BIT_MODE_HI:BIT_MODE_LO] = r.mode;
					s.rdata[BIT_FILTER] = r.filt;
					s.rdata[BIT_RX_ENABLE] = r.ren;
					s.rdata[BIT_TX_NINTH] = r.tx9;
					s.rdata[BIT_RX_NINTH] = r.rx9;
					s.rdata[BIT_TX_DONE] = r.txdone;
					s.rdata[BIT_RX_DONE] = r.rxdone;
				end
				ADDR_SERIAL_BUFFER: s.rdata = r.rxbuf;
				ADDR_POWER_CONTROL: s.rdata[BIT_BAUD_DOUBLE] = r.dbl;
				ADDR_TIMER2_CONTROL: begin
					s.rdata[BIT_RX_T2_SEL] = r.rx_t2;
					s.rdata[BIT_TX_T2_SEL] = r.tx_t2;
				end
				ADDR_TIMER1_RELOAD_HIGH: s.rdata = r.th1;
				ADDR_TIMER2_RELOAD_HIGH: s.rdata = r.rc2h;
				ADDR_TIMER2_RELOAD_LOW: s.rdata = r.rc2l;
				ADDR_CLOCK_CONFIG: s.rdata[BIT_SIX_CLOCK] = r.six;
				default: ;
			endcase
		end

		// ****************************************
		// Asynchronous transmitter
		// ****************************************
		unique case (r.tx_st)
			SP4_TX_IDLE: begin
				if (serial_buffer_wr && r.mode != SP4_M_SYNC) begin
					// Mode 1 sends stop in the ninth slot too
					s.tx_sh = {1'b1, (r.mode == SP4_M_UART8) ? 1'b1 : r.tx9, reg_wdata, 1'b0};
					s.tx_sub = 4'h0;
					s.tx_bit = 4'h0;
					s.tx_st = SP4_TX_RUN;
				end
			end
			SP4_TX_RUN: begin
				if (tx_tick) begin
					s.tx_sub = r.tx_sub + 4'h1;
					if (r.tx_sub == SUB_LAST) begin
						if (r.tx_bit == tx_last) begin
							s.tx_st = SP4_TX_IDLE;
						end else begin
							s.tx_sh = {1'b1, r.tx_sh[10:1]};
							s.tx_bit = r.tx_bit + 4'h1;
							tx_set = (r.tx_bit + 4'h1 == tx_last);
						end
					end
				end
			end
		endcase

		// ****************************************
		// Asynchronous receiver
		// ****************************************
		s.rx_prev = rxd_s;
		unique case (r.rx_st)
			SP4_RX_IDLE: begin
				if (r.ren && r.mode != SP4_M_SYNC && r.rx_prev && !rxd_s) begin
					s.rx_sub = 4'h0;
					s.rx_bit = 4'h0;
					s.rx_st = SP4_RX_RUN;
				end
			end
			SP4_RX_RUN: begin
				if (rx_tick) begin
					s.rx_sub = r.rx_sub + 4'h1;
					if (r.rx_sub == SUB_MID) begin
						if (r.rx_bit == 4'h0) begin
							// Glitch, not a start bit
							if (rxd_s) begin
								s.rx_st = SP4_RX_IDLE;
							end
						end else if (r.rx_bit == DECIDE_BIT) begin
							// Stop bit in mode 1, ninth bit otherwise; then rearm
							s.rx_st = SP4_RX_IDLE;
							if (!r.rxdone && (!r.filt || rxd_s)) begin
								s.rxbuf = r.rx_sh;
								s.rx9 = rxd_s;
								rx_set = 1'b1;
							end
						end else begin
							s.rx_sh = {rxd_s, r.rx_sh[7:1]};
						end
					end
					if (r.rx_sub == SUB_LAST) begin
						s.rx_bit = r.rx_bit + 4'h1;
					end
				end
				if (!r.ren) begin
					s.rx_st = SP4_RX_IDLE;
				end
			end
		endcase

		// ****************************************
		// Synchronous shifter
		// ****************************************
		unique case (r.m0_st)
			SP4_S0_IDLE: begin
				if (r.mode == SP4_M_SYNC) begin
					s.m0_ph = 4'h0;
					s.m0_bit = 4'h0;
					if (serial_buffer_wr) begin
						s.m0_sh = reg_wdata;
						s.m0_st = SP4_S0_TX;
					end else if (r.ren && !r.rxdone) begin
						s.m0_st = SP4_S0_RX;
					end
				end
			end
			SP4_S0_TX, SP4_S0_RX: begin
				s.m0_ph = r.m0_ph + 4'h1;
				if (r.m0_ph == m0_per - 4'h1) begin
					// Sample late in the high phase, after sync delay
					s.m0_ph = 4'h0;
					s.m0_bit = r.m0_bit + 4'h1;
					s.m0_sh = {(r.m0_st == SP4_S0_RX) ? rxd_s : 1'b0, r.m0_sh[7:1]};
					if (r.m0_bit == M0_LAST_BIT) begin
						s.m0_st = SP4_S0_IDLE;
						if (r.m0_st == SP4_S0_TX) begin
							tx_set = 1'b1;
						end else begin
							s.rxbuf = s.m0_sh;
							rx_set = 1'b1;
						end
					end
				end
			end
			default: s.m0_st = SP4_S0_IDLE;
		endcase

		// Set beats a same-cycle software clear
		s.txdone = s.txdone | tx_set;
		s.rxdone = s.rxdone | rx_set;

		// ****************************************
		// Pin drive
		// ****************************************
		s.doe = (s.m0_st == SP4_S0_TX);
		s.dout = s.m0_sh[0];
		if (s.mode == SP4_M_SYNC) begin
			// One shift clock period per bit
			s.txd = (s.m0_st == SP4_S0_IDLE) || s.m0_ph >= (m0_per >> 1);
		end else begin
			s.txd = (s.tx_st == SP4_TX_IDLE) || s.tx_sh[0];
		end
		s.supp = s.rx_t2 | s.tx_t2;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			r <= '0;
			r.txd <= 1'b1;
		end else begin
			r <= s;
		end
	end

	assign reg_rdata = r.rdata;
	assign data_pin_out = r.dout;
	assign data_pin_oe = r.doe;
	assign txd_pin_out = r.txd;
	assign timer2_irq_suppress = r.supp;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	logic m0_tx_start;
	logic as_tx_start;
	logic rx_decide;
	assign m0_tx_start = r.m0_st == SP4_S0_IDLE && r.mode == SP4_M_SYNC && serial_buffer_wr;
	assign as_tx_start = r.tx_st == SP4_TX_IDLE && r.mode != SP4_M_SYNC && serial_buffer_wr;
	assign rx_decide = r.rx_st == SP4_RX_RUN && rx_tick && r.rx_sub == SUB_MID && r.rx_bit == DECIDE_BIT;

	sequence seq_clk_low6;
		!txd_pin_out [*6];
	endsequence
	sequence seq_clk_high6;
		txd_pin_out [*6];
	endsequence

	AST_M0_OE_SYNC_ONLY: assert property (data_pin_oe |-> r.mode == SP4_M_SYNC)
		else $error("data pin driven outside sync mode");
	AST_M0_TX_DONE: assert property (m0_tx_start && !r.six |-> ##97 r.txdone)
		else $error("sync transmit done flag late");
	AST_M0_CLOCK_SHAPE: assert property (
		r.m0_st != SP4_S0_IDLE && r.m0_ph == 4'h0 && !r.six && r.m0_bit != M0_LAST_BIT
		|-> seq_clk_low6 ##1 seq_clk_high6)
		else $error("shift clock not 6 low 6 high");
	AST_ASYNC_START_BIT: assert property (as_tx_start |=> !txd_pin_out)
		else $error("start bit missing");
	AST_RX_REJECT_BUSY: assert property (rx_decide && r.rxdone |=> $stable(r.rxbuf))
		else $error("buffer overwritten while full");
	AST_RX_ACCEPT: assert property (
		rx_decide && !r.rxdone && (!r.filt || rxd_s) |=> r.rxdone && r.rx9 == $past(rxd_s))
		else $error("accepted frame not stored");
	AST_M2_TICK_RATE: assert property (
		(r.m2tick && !r.six && !r.dbl && !reg_wr) ##1 (!reg_wr [*2]) |-> (!$past(r.m2tick) && !r.m2tick) ##1 !r.m2tick ##1 r.m2tick)
		else $error("mode 2 tick not every 4 cycles");
	AST_T2_SUPPRESS: assert property (timer2_irq_suppress == (r.tx_t2 || r.rx_t2))
		else $error("timer 2 interrupt not suppressed");

endmodule : sp4_serial_port

//--- test/sp4_far_node.sv
// Far side of the serial port: remote async node and sync shift peripheral.
// Assumes the bench feeds back the resolved data pin level and the clock/tx pin.
`timescale 1ns/1ns
module sp4_far_node (
	// Clock
	input wire logic core_clk,
	// Pins seen from the far side
	input wire logic txd_lvl,
	input wire logic data_lvl,
	output logic line
);
	logic [7:0] sbyte;
	int scnt = 0;
	initial line = 1'b1;

	// ****************************************
	// Sync peripheral
	// ****************************************
	// Next bit on falling shift clock, LSB first
	always @(negedge txd_lvl) begin
		if (scnt > 0) begin
			line <= sbyte[8 - scnt];
			scnt <= scnt - 1;
		end
	end

	task arm_sync(input logic [7:0] b);
		sbyte = b;
		scnt = 8;
	endtask : arm_sync

	// Peripheral lets go of the data line, pull-up brings it high
	task release_line();
		line <= 1'b1;
	endtask : release_line

	// Data settled at the rising shift clock; also times that clock
	task get_sync(output logic [7:0] b, output time per);
		time t0;
		for (int i = 0; i < 8; i++) begin
			@(posedge txd_lvl);
			if (i == 0) t0 = $time;
			b[i] = data_lvl;
		end
		per = ($time - t0) / 7;
	endtask : get_sync

	// ****************************************
	// Async node
	// ****************************************
	// Start, 8 data LSB first, ninth or stop, then idle high
	task send(input logic [10:0] f, input int p);
		for (int i = 0; i < 11; i++) begin
			@(posedge core_clk);
			line <= f[i];
			repeat (p - 1) @(posedge core_clk);
		end
		@(posedge core_clk);
		line <= 1'b1;
	endtask : send

	// Samples at mid bit from the start edge
	task get_async(output logic [10:0] f, input int p);
		@(negedge txd_lvl);
		repeat (p / 2) @(posedge core_clk);
		for (int i = 0; i < 11; i++) begin
			f[i] = txd_lvl;
			repeat (p) @(posedge core_clk);
		end
	endtask : get_async
endmodule : sp4_far_node

//--- test/tb_top.sv
// Self-checking bench for the four-mode serial port.
// Assumes the far node model drives the receive level and watches the pins.
`timescale 1ns/1ns
module tb_top import sp4_pkg::*;;
	logic core_clk, reset_n, reg_wr, reg_rd, b, nin;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rx_last, got, x, y;
	logic data_pin_in, data_pin_out, data_pin_oe, txd_pin_out, timer2_irq_suppress, far_line;
	logic [10:0] fr;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	time tp;
	localparam logic [4:0] CASES [7] = '{5'h10, 5'h14, 5'h16, 5'h13, 5'h0c, 5'h0e, 5'h1c};

	// Resolved data pin: port when enabled, else far side
	assign data_pin_in = data_pin_oe ? data_pin_out : far_line;

	sp4_serial_port dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_pin_in(data_pin_in),
		.data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .txd_pin_out(txd_pin_out),
		.timer2_irq_suppress(timer2_irq_suppress));
	sp4_far_node far (.core_clk(core_clk), .txd_lvl(txd_pin_out), .data_lvl(data_pin_in), .line(far_line));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Slow first timer 2 overflow dominates the run length
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			miscompares++;
			$display("unexpected at %0t: timeout", $time);
			finish_test();
		end
	end

	// ****************************************
	// Checks and bus
	// ****************************************
	task chk(input logic [10:0] g, input logic [10:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	task chk_t(input time g, input time e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: period %0d want %0d", $time, g, e);
		end
	endtask : chk_t

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task rchk(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk({3'h0, d}, {3'h0, e});
	endtask : rchk

	task wait_flag(input int i);
		logic [7:0] d;
		d = 8'h00;
		for (int n = 0; n < 100 && d[i] !== 1'b1; n++) rd(ADDR_SERIAL_CONTROL, d);
		chk({10'h0, d[i]}, 11'h1);
	endtask : wait_flag

	// ****************************************
	// Expectations
	// ****************************************
	function automatic int bit_cyc(int m, int t2, int d, int s);
		if (m == 2) return 64 >> (d + s);
		if (t2 != 0) return 64 >> s;
		return 384 >> (d + s);
	endfunction : bit_cyc

	function automatic logic [10:0] frame(int m, logic [7:0] d, logic n);
		return {1'b1, (m == 1) ? 1'b1 : n, d, 1'b0};
	endfunction : frame

	function automatic logic [7:0] ctl(int m, logic f, logic t, logic r, logic [1:0] fl);
		return {2'(m), f, 1'b1, t, r, fl};
	endfunction : ctl

	task cfg(input int t2, input int d, input int s, input logic [7:0] c);
		wr(ADDR_POWER_CONTROL, 8'(d << BIT_BAUD_DOUBLE));
		wr(ADDR_CLOCK_CONFIG, 8'(s << BIT_SIX_CLOCK));
		wr(ADDR_TIMER2_CONTROL, 8'(t2 * 8'h30));
		wr(ADDR_TIMER1_RELOAD_HIGH, 8'hff); // Timer 1 has no interrupt here to mask
		wr(ADDR_TIMER2_RELOAD_HIGH, 8'hff);
		wr(ADDR_TIMER2_RELOAD_LOW, 8'hfe);
		wr(ADDR_SERIAL_CONTROL, c);
		repeat (2) @(posedge core_clk);
		chk({10'h0, timer2_irq_suppress}, 11'(t2));
	endtask : cfg

	task finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// Timers count up from zero after reset, so the first overflow of each is late
	task warm(input int t2);
		logic [7:0] d;
		d = 8'h00;
		cfg(t2, 1, 1, ctl(1, 1'b0, 1'b0, nin, 2'h0));
		wr(ADDR_SERIAL_BUFFER, 8'hff);
		while (d[BIT_TX_DONE] !== 1'b1) rd(ADDR_SERIAL_CONTROL, d);
		repeat (200) @(posedge core_clk);
		$display("test warm source %0d done", t2);
	endtask : warm

	// ****************************************
	// Async send and receive over every rate source
	// ****************************************
	task async_pass(input int t2);
		int p;
		for (int m = 1; m < 4; m++) begin
			for (int d = 0; d < 2; d++) begin
				for (int s = 1; s >= 0; s--) begin
					if (m == 2 && t2 == 1) continue;
					p = bit_cyc(m, t2, d, s);
					x = 8'($urandom);
					b = 1'($urandom);
					cfg(t2, d, s, ctl(m, 1'b0, b, nin, 2'h0));
					fork
						far.get_async(fr, p);
						begin
							wr(ADDR_SERIAL_BUFFER, x);
							rchk(ADDR_SERIAL_BUFFER, rx_last);
						end
					join
					chk(fr, frame(m, x, b));
					rchk(ADDR_SERIAL_CONTROL, ctl(m, 1'b0, b, nin, 2'h2));
					y = 8'($urandom);
					nin = (m == 1) ? 1'b1 : 1'($urandom);
					far.send(frame(2, y, nin), p);
					rchk(ADDR_SERIAL_BUFFER, y);
					rchk(ADDR_SERIAL_CONTROL, ctl(m, 1'b0, b, nin, 2'h3));
					rx_last = y;
					$display("test async mode %0d src %0d dbl %0d six %0d done", m, t2, d, s);
				end
			end
		end
	endtask : async_pass

	initial begin
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reset_n = 1'b0;
		nin = 1'b0;
		void'($urandom(34));
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 8; a++) rchk(3'(a), RESET_BYTE);
		$display("test reset done");
		// Sync shifter: send, then two receives, the second started by clearing the flag
		for (int s = 1; s >= 0; s--) begin
			x = 8'($urandom);
			y = 8'($urandom);
			cfg(0, 0, s, 8'h00);
			fork
				far.get_sync(got, tp);
				wr(ADDR_SERIAL_BUFFER, x);
			join
			chk({3'h0, got}, {3'h0, x});
			chk_t(tp, (12 >> s) * 100);
			wait_flag(1);
			far.arm_sync(y);
			wr(ADDR_SERIAL_CONTROL, 8'h10);
			wait_flag(0);
			rchk(ADDR_SERIAL_BUFFER, y);
			far.arm_sync(~y);
			wr(ADDR_SERIAL_CONTROL, 8'h10);
			wait_flag(0);
			rchk(ADDR_SERIAL_BUFFER, ~y);
			wr(ADDR_SERIAL_CONTROL, 8'h00);
			far.release_line();
			$display("test sync six %0d done", s);
		end
		rx_last = ~y;
		warm(0);
		async_pass(0);
		// Acceptance table: mode, filter, ninth or stop bit, flag already set
		for (int k = 0; k < 7; k++) begin
			logic [4:0] cs;
			logic acc;
			cs = CASES[k];
			acc = !cs[0] && (!cs[2] || cs[1]);
			y = 8'($urandom);
			cfg(0, 1, 1, ctl(cs[4:3], cs[2], 1'b0, nin, {1'b0, cs[0]}));
			far.send(frame(2, y, cs[1]), bit_cyc(cs[4:3], 0, 1, 1));
			if (acc) begin
				rx_last = y;
				nin = cs[1];
			end
			rchk(ADDR_SERIAL_BUFFER, rx_last);
			rchk(ADDR_SERIAL_CONTROL, ctl(cs[4:3], cs[2], 1'b0, nin, {1'b0, cs[0] | acc}));
			$display("test accept case %0d done", k);
		end
		warm(1);
		async_pass(1);
		finish_test();
	end
endmodule : tb_top
